// [qctc_pkg.sv]
// qctc_pkg.sv - constants and carrier types of the quad counter/timer
package qctc_pkg;

  // ----------------------------------------------------
  // register indices
  // ----------------------------------------------------
  localparam logic [4:0] A_T01_CTL  = 5'h00;
  localparam logic [4:0] A_T01_MODE = 5'h01;
  localparam logic [4:0] A_CLK_CTL  = 5'h02;
  localparam logic [4:0] A_T0_LOW   = 5'h03;
  localparam logic [4:0] A_T0_HIGH  = 5'h04;
  localparam logic [4:0] A_T1_LOW   = 5'h05;
  localparam logic [4:0] A_T1_HIGH  = 5'h06;
  localparam logic [4:0] A_T2_BASE  = 5'h07;
  localparam logic [4:0] A_T3_BASE  = 5'h0C;
  // offsets inside a timer 2/3 group
  localparam logic [4:0] OFF_CTL    = 5'h00;
  localparam logic [4:0] OFF_CNT_L  = 5'h01;
  localparam logic [4:0] OFF_CNT_H  = 5'h02;
  localparam logic [4:0] OFF_RLD_L  = 5'h03;
  localparam logic [4:0] OFF_RLD_H  = 5'h04;

  // ----------------------------------------------------
  // field positions
  // ----------------------------------------------------
  // timer 0/1 control: run, gate, counter mode per timer
  localparam int T_RUN      = 0;
  localparam int T_GATE     = 1;
  localparam int T_CNTMODE  = 2;
  localparam int T_STRIDE   = 3;
  localparam int TIMER0_OVERFLOW_FLAG = 6;
  localparam int TIMER1_OVERFLOW_FLAG = 7;
  // mode register: 2-bit mode per timer, gate polarity
  localparam int MODE_POL   = 4;
  localparam logic [1:0] MODE_13    = 2'h0;
  localparam logic [1:0] MODE_16    = 2'h1;
  localparam logic [1:0] MODE_8R    = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // clock control: prescale_code, timer01_system_clock_select
  localparam int PRESCALE_LSB = 0;
  localparam int SYSTEM_CLOCK_SEL   = 2;
  localparam logic [1:0] PS_DIV12 = 2'h0;
  localparam logic [1:0] PS_DIV4  = 2'h1;
  localparam logic [1:0] PS_DIV48 = 2'h2;
  localparam logic [1:0] PS_EXT8  = 2'h3;
  // timer 2/3 control
  localparam int X_RUN     = 0;
  localparam int X_SPLIT   = 1;
  localparam int X_CAPTURE = 2;
  localparam int X_SRC     = 3;
  localparam int X_SYSTEM_CLOCK  = 5;
  localparam int X_FLAG_H  = 6;
  localparam int X_FLAG_L  = 7;
  localparam logic [1:0] SRC_OSC8 = 2'h1;
  localparam logic [1:0] SRC_CMP  = 2'h2;

  // ----------------------------------------------------
  // divider counts
  // ----------------------------------------------------
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [1:0] DIV48_LAST = 2'h3;
  localparam logic [2:0] DIV8_LAST  = 3'h7;

  // ----------------------------------------------------
  // synchroniser bit positions
  // ----------------------------------------------------
  localparam int S_TIMER0_GATE_ENABLE  = 2;
  localparam int S_EXTCLK = 4;
  localparam int S_CMP0   = 7;
  localparam int SYNC_W   = 9;

  // ----------------------------------------------------
  // carrier types
  // ----------------------------------------------------
  typedef struct packed {
    logic comparator1;          // comparator 1 output
    logic comparator0;          // comparator 0 output
    logic extosc_clock;         // external oscillator
    logic rtc_clock;            // real-time clock oscillator
    logic ext_clock;            // external prescaler clock
    logic external_gate_input1; // timer 1 gate
    logic external_gate_input0; // timer 0 gate
    logic timer1_count_pin;     // timer 1 event pin
    logic timer0_count_pin;     // timer 0 event pin
  } qctc_pins_type;

  typedef struct packed {
    logic       rd;             // read strobe
    logic       wr;             // write strobe
    logic [4:0] addr;           // register index
    logic [7:0] wdata;          // write data
  } qctc_bus_type;

  typedef struct packed {
    logic [7:0]             ctl;    // timer 0/1 control
    logic [7:0]             mode;   // timer 0/1 mode
    logic [7:0]             clk;    // clock control
    logic [1:0][15:0]       cnt01;  // timer 0/1 count
    logic [1:0][7:0]        ctl23;  // timer 2/3 control
    logic [1:0][15:0]       cnt23;  // timer 2/3 count
    logic [1:0][15:0]       rld23;  // timer 2/3 reload
    logic [3:0]             pre12;  // divide by 12
    logic [1:0]             pre48;  // quarter of /48
    logic [2:0][2:0]        div8;   // /8 of slow clocks
    logic [SYNC_W-1:0]      s1;     // first sync stage
    logic [SYNC_W-1:0]      s2;     // second sync stage
    logic [SYNC_W-1:0]      s3;     // edge history
    logic [7:0]             rdata;  // read data
  } qctc_state_type;

  localparam qctc_state_type ST_RESET = '0;

endpackage

// [qctc_top.sv]
// qctc_top.sv - quad counter/timer with clock selection and pin counting
`timescale 1ns/1ps
`default_nettype none
module qctc_top (
  // clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    reset_n_in,
  // register port
  input  wire qctc_pkg::qctc_bus_type  bus_in,
  output logic [7:0]                   rd_data_out,
  // asynchronous pins
  input  wire qctc_pkg::qctc_pins_type pins_in,
  // overflow flags
  output logic                         timer0_overflow_flag_out,
  output logic [5:0]                   overflow_flags_out
);

  // ----------------------------------------------------
  // state and derived strobes
  // ----------------------------------------------------
  qctc_pkg::qctc_state_type st;       // registered state
  qctc_pkg::qctc_state_type nx;       // next state
  logic [qctc_pkg::SYNC_W-1:0] rise;  // synced rising edges
  logic [qctc_pkg::SYNC_W-1:0] fall;  // synced falling edges
  logic       tick12;                 // system clock / 12
  logic       tick4;                  // system clock / 4
  logic       tick48;                 // system clock / 48
  logic [2:0] tick8;                  // ext, rtc, osc / 8
  logic       pre_tick;               // shared prescaled clock
  logic [1:0] t_tick;                 // timer 0/1 clock
  logic [1:0] go;                     // timer 0/1 count now
  logic       go_h;                   // split high byte count

  // edges read only the second stage and its history
  assign rise = st.s2 & ~st.s3;
  assign fall = ~st.s2 & st.s3;

  // one counter gives /12 and /4; /48 is four /12 ticks
  assign tick12 = st.pre12 == qctc_pkg::DIV12_LAST;
  assign tick4  = st.pre12[1:0] == qctc_pkg::DIV4_LAST;
  assign tick48 = tick12 && st.pre48 == qctc_pkg::DIV48_LAST;

  // ----------------------------------------------------
  // slow clock dividers, one per source
  // ----------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_div8
      // a tick on every eighth synced rising edge
      assign tick8[g] = rise[qctc_pkg::S_EXTCLK+g] &&
                        st.div8[g] == qctc_pkg::DIV8_LAST;
    end
  endgenerate

  // prescaled clock shared by timers 0 and 1
  always_comb begin
    case (st.clk[qctc_pkg::PRESCALE_LSB +: 2])
      qctc_pkg::PS_DIV12: pre_tick = tick12;
      qctc_pkg::PS_DIV4:  pre_tick = tick4;
      qctc_pkg::PS_DIV48: pre_tick = tick48;
      default:            pre_tick = tick8[0];
    endcase
  end

  // ----------------------------------------------------
  // timer 0/1 clock and run condition
  // ----------------------------------------------------
  generate
    for (g = 0; g < 2; g++) begin : gen_t01
      logic gate_ok;  // gate off or gate pin active
      // pin events, else system clock or prescaled clock
      assign t_tick[g] =
        st.ctl[qctc_pkg::T_STRIDE*g+qctc_pkg::T_CNTMODE] ?
        fall[g] :
        (st.clk[qctc_pkg::SYSTEM_CLOCK_SEL+g] | pre_tick);
      assign gate_ok =
        !st.ctl[qctc_pkg::T_STRIDE*g+qctc_pkg::T_GATE] ||
        st.s2[qctc_pkg::S_TIMER0_GATE_ENABLE+g] ==
        st.mode[qctc_pkg::MODE_POL+g];
      assign go[g] = st.ctl[qctc_pkg::T_STRIDE*g+qctc_pkg::T_RUN]
                     && gate_ok && t_tick[g];
    end
  endgenerate

  // split high byte runs off timer 1's run bit, no gate
  assign go_h = st.ctl[qctc_pkg::T_STRIDE+qctc_pkg::T_RUN] &&
                t_tick[0];

  // ----------------------------------------------------
  // next state
  // ----------------------------------------------------
  always_comb begin
    logic [15:0] c;     // working count
    logic [15:0] r;     // working reload
    logic [7:0]  cf;    // timer 2/3 control
    logic [12:0] v13;   // 13-bit increment
    logic [5:0]  setf;  // hardware flag sets
    logic        tk;    // timer 2/3 clock
    logic        ev;    // selected source event
    logic        own;   // timer may set its flag
    logic [4:0]  base;  // timer 2/3 group index
    logic [7:0]  rv;    // read value
    nx   = st;
    c    = '0;
    r    = '0;
    cf   = '0;
    v13  = '0;
    setf = '0;
    tk   = 1'b0;
    ev   = 1'b0;
    own  = 1'b0;
    base = '0;
    rv   = '0;
    // two-stage synchroniser, then history for edges
    nx.s1 = pins_in;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    // free running prescaler
    nx.pre12 = tick12 ? 4'h0 : st.pre12 + 4'h1;
    if (tick12) begin
      nx.pre48 = st.pre48 + 2'h1;
    end
    for (int k = 0; k < 3; k++) begin
      if (rise[qctc_pkg::S_EXTCLK+k]) begin
        nx.div8[k] = st.div8[k] + 3'h1;
      end
    end
    // timers 0 and 1
    for (int i = 0; i < 2; i++) begin
      c   = st.cnt01[i];
      v13 = {c[15:8], c[4:0]} + 13'h0001;
      // timer 1 loses its flag while timer 0 is split
      own = !(i == 1 &&
              st.mode[1:0] == qctc_pkg::MODE_SPLIT);
      case (st.mode[2*i +: 2])
        qctc_pkg::MODE_13: begin
          // upper three low-byte bits are left untouched
          if (go[i]) begin
            c[15:8] = v13[12:5];
            c[4:0]  = v13[4:0];
            setf[i] = setf[i] | (own && v13 == '0);
          end
        end
        qctc_pkg::MODE_16: begin
          if (go[i]) begin
            c       = c + 16'h0001;
            setf[i] = setf[i] | (own && c == '0);
          end
        end
        qctc_pkg::MODE_8R: begin
          if (go[i] && c[7:0] == 8'hFF) begin
            c[7:0]  = c[15:8];
            setf[i] = setf[i] | own;
          end else if (go[i]) begin
            c[7:0] = c[7:0] + 8'h01;
          end
        end
        default: begin
          // split is timer 0 only; timer 1 holds in it
          if (i == 0) begin
            if (go[0]) begin
              c[7:0]  = c[7:0] + 8'h01;
              setf[0] = c[7:0] == 8'h00;
            end
            if (go_h) begin
              c[15:8] = c[15:8] + 8'h01;
              setf[1] = c[15:8] == 8'h00;
            end
          end
        end
      endcase
      nx.cnt01[i] = c;
    end
    // timers 2 and 3
    for (int j = 0; j < 2; j++) begin
      cf = st.ctl23[j];
      c  = st.cnt23[j];
      r  = st.rld23[j];
      case (cf[qctc_pkg::X_SRC +: 2])
        qctc_pkg::SRC_OSC8: ev = tick8[1+j];
        qctc_pkg::SRC_CMP:  ev = rise[qctc_pkg::S_CMP0+j];
        default:            ev = tick12;
      endcase
      // capture counts the reference, source marks edges
      tk = cf[qctc_pkg::X_SYSTEM_CLOCK] |
           (cf[qctc_pkg::X_CAPTURE] ? tick12 : ev);
      if (cf[qctc_pkg::X_RUN] && cf[qctc_pkg::X_CAPTURE]) begin
        if (tk) begin
          c = c + 16'h0001;
        end
        if (ev) begin
          r           = st.cnt23[j];
          setf[2+2*j] = 1'b1;
        end
      end else if (cf[qctc_pkg::X_RUN] && cf[qctc_pkg::X_SPLIT]) begin
        if (tk && c[7:0] == 8'hFF) begin
          c[7:0]      = r[7:0];
          setf[3+2*j] = 1'b1;
        end else if (tk) begin
          c[7:0] = c[7:0] + 8'h01;
        end
        if (tk && c[15:8] == 8'hFF) begin
          c[15:8]     = r[15:8];
          setf[2+2*j] = 1'b1;
        end else if (tk) begin
          c[15:8] = c[15:8] + 8'h01;
        end
      end else if (cf[qctc_pkg::X_RUN] && tk) begin
        if (c == 16'hFFFF) begin
          c           = r;
          setf[2+2*j] = 1'b1;
        end else begin
          c = c + 16'h0001;
        end
      end
      nx.cnt23[j] = c;
      nx.rld23[j] = r;
    end
    // software writes take the register over
    if (bus_in.wr) begin
      case (bus_in.addr)
        qctc_pkg::A_T01_CTL:  nx.ctl = bus_in.wdata;
        qctc_pkg::A_T01_MODE: nx.mode = bus_in.wdata;
        qctc_pkg::A_CLK_CTL:  nx.clk = bus_in.wdata;
        qctc_pkg::A_T0_LOW:   nx.cnt01[0][7:0] = bus_in.wdata;
        qctc_pkg::A_T0_HIGH:  nx.cnt01[0][15:8] = bus_in.wdata;
        qctc_pkg::A_T1_LOW:   nx.cnt01[1][7:0] = bus_in.wdata;
        qctc_pkg::A_T1_HIGH:  nx.cnt01[1][15:8] = bus_in.wdata;
        default: ;
      endcase
    end
    // read mux for the shared registers
    case (bus_in.addr)
      qctc_pkg::A_T01_CTL:  rv = st.ctl;
      qctc_pkg::A_T01_MODE: rv = st.mode;
      qctc_pkg::A_CLK_CTL:  rv = st.clk;
      qctc_pkg::A_T0_LOW:   rv = st.cnt01[0][7:0];
      qctc_pkg::A_T0_HIGH:  rv = st.cnt01[0][15:8];
      qctc_pkg::A_T1_LOW:   rv = st.cnt01[1][7:0];
      qctc_pkg::A_T1_HIGH:  rv = st.cnt01[1][15:8];
      default:              rv = '0;
    endcase
    for (int j = 0; j < 2; j++) begin
      base = (j == 1) ? qctc_pkg::A_T3_BASE : qctc_pkg::A_T2_BASE;
      if (bus_in.addr == base + qctc_pkg::OFF_CTL) begin
        rv = st.ctl23[j];
        if (bus_in.wr) nx.ctl23[j] = bus_in.wdata;
      end
      if (bus_in.addr == base + qctc_pkg::OFF_CNT_L) begin
        rv = st.cnt23[j][7:0];
        if (bus_in.wr) nx.cnt23[j][7:0] = bus_in.wdata;
      end
      if (bus_in.addr == base + qctc_pkg::OFF_CNT_H) begin
        rv = st.cnt23[j][15:8];
        if (bus_in.wr) nx.cnt23[j][15:8] = bus_in.wdata;
      end
      if (bus_in.addr == base + qctc_pkg::OFF_RLD_L) begin
        rv = st.rld23[j][7:0];
        if (bus_in.wr) nx.rld23[j][7:0] = bus_in.wdata;
      end
      if (bus_in.addr == base + qctc_pkg::OFF_RLD_H) begin
        rv = st.rld23[j][15:8];
        if (bus_in.wr) nx.rld23[j][15:8] = bus_in.wdata;
      end
      // a hardware set beats a software clear
      nx.ctl23[j][qctc_pkg::X_FLAG_H] =
        nx.ctl23[j][qctc_pkg::X_FLAG_H] | setf[2+2*j];
      nx.ctl23[j][qctc_pkg::X_FLAG_L] =
        nx.ctl23[j][qctc_pkg::X_FLAG_L] | setf[3+2*j];
    end
    nx.ctl[qctc_pkg::TIMER0_OVERFLOW_FLAG] =
      nx.ctl[qctc_pkg::TIMER0_OVERFLOW_FLAG] | setf[0];
    nx.ctl[qctc_pkg::TIMER1_OVERFLOW_FLAG] =
      nx.ctl[qctc_pkg::TIMER1_OVERFLOW_FLAG] | setf[1];
    // read data stand only in the cycle after the strobe
    nx.rdata = bus_in.rd ? rv : 8'h00;
  end

  // ----------------------------------------------------
  // state register
  // ----------------------------------------------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= qctc_pkg::ST_RESET;
    end else begin
      st <= nx;
    end
  end

  // outputs straight from flip-flops
  assign rd_data_out = st.rdata;
  assign timer0_overflow_flag_out =
    st.ctl[qctc_pkg::TIMER0_OVERFLOW_FLAG];
  assign overflow_flags_out = {st.ctl23[1][7:6], st.ctl23[0][7:6],
                               st.ctl[7:6]};

  // ----------------------------------------------------
  // assertions
  // ----------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  a_t0_wrap13: assert property (
    (st.mode[1:0] == qctc_pkg::MODE_13 && go[0] && !bus_in.wr &&
     {st.cnt01[0][15:8], st.cnt01[0][4:0]} == 13'h1FFF) |=>
    (timer0_overflow_flag_out && st.cnt01[0][15:8] == 8'h00 &&
     st.cnt01[0][4:0] == 5'h00))
    else $error("13-bit wrap did not clear count and set flag");

  a_t0_reload8: assert property (
    (st.mode[1:0] == qctc_pkg::MODE_8R && go[0] && !bus_in.wr &&
     st.cnt01[0][7:0] == 8'hFF) |=>
    (st.cnt01[0][7:0] == $past(st.cnt01[0][15:8]) &&
     $stable(st.cnt01[0][15:8])))
    else $error("8-bit reload did not copy the high byte");

  a_t0_hold_stopped: assert property (
    (!go[0] && !bus_in.wr &&
     st.mode[1:0] != qctc_pkg::MODE_SPLIT) |=> $stable(st.cnt01[0]))
    else $error("timer 0 changed while not running");

  a_t0_gate_closed: assert property (
    (st.ctl[1:0] == 2'h3 && st.s2[qctc_pkg::S_TIMER0_GATE_ENABLE] != st.mode[4])
    |-> !go[0])
    else $error("timer 0 counted with its gate closed");

  a_pin_counts: assert property (
    (st.ctl[2:0] == 3'h5 && st.mode[1:0] == qctc_pkg::MODE_16 &&
     fall[0] && !bus_in.wr) |=>
    st.cnt01[0] == $past(st.cnt01[0]) + 16'h0001)
    else $error("pin falling edge did not count once");

  a_sync_depth: assert property (
    fall[0] |-> ($past(pins_in.timer0_count_pin, 2) == 1'b0 &&
                 $past(pins_in.timer0_count_pin, 3) == 1'b1))
    else $error("count edge not from two-stage synchroniser");

  a_div12_period: assert property (
    tick12 |=> (!tick12)[*8] ##1 (!tick12)[*3] ##1 tick12)
    else $error("divide by 12 period wrong");

  a_t2_reload16: assert property (
    (st.ctl23[0][2:0] == 3'h1 && st.ctl23[0][qctc_pkg::X_SYSTEM_CLOCK] &&
     st.cnt23[0] == 16'hFFFF && !bus_in.wr) |=>
    (st.cnt23[0] == $past(st.rld23[0]) &&
     st.ctl23[0][qctc_pkg::X_FLAG_H]))
    else $error("timer 2 16-bit reload failed");

  a_t3_capture: assert property (
    (st.ctl23[1][2:0] == 3'h5 &&
     st.ctl23[1][4:3] == qctc_pkg::SRC_CMP &&
     rise[qctc_pkg::S_CMP0+1] && !bus_in.wr) |=>
    (st.rld23[1] == $past(st.cnt23[1]) &&
     st.ctl23[1][qctc_pkg::X_FLAG_H]))
    else $error("timer 3 capture missed comparator edge");

  c_t0_wrap: cover property (go[0] ##1 timer0_overflow_flag_out);
  c_t3_capture: cover property (st.ctl23[1][2] && rise[8]);
  c_t0_split: cover property (go_h && st.mode[1:0] == 2'h3);

endmodule
`default_nettype wire

// [qctc_pin_model.sv]
// qctc_pin_model.sv - behavioural model of the pins around the timers
`timescale 1ns/1ps
`default_nettype none
module qctc_pin_model (
  // clock
  input  wire logic               clock_in,
  // pins toward the timers
  output qctc_pkg::qctc_pins_type pins_out
);
  logic       count0;   // timer 0 event pin level
  logic       timer0_gate_enable;    // timer 0 gate pin level
  logic       osc;      // external prescale oscillator
  logic [1:0] osc_cnt;  // half period counter
  logic       cmp1;     // comparator 1 output level

  // ------------------------------------------------------------
  // pin assembly
  // ------------------------------------------------------------
  // unused sources sit at a quiet level, no scenario needs them
  assign pins_out = '{timer0_count_pin: count0,
                      external_gate_input0: timer0_gate_enable,
                      ext_clock: osc, comparator1: cmp1,
                      default: 1'b0};

  initial begin
    count0 = 1'b1;
    timer0_gate_enable  = 1'b0;
    osc    = 1'b0;
    osc_cnt = 2'h0;
    cmp1    = 1'b0;
  end

  // oscillator runs free, 8 system clocks a period
  always @(posedge clock_in) begin
    osc_cnt <= osc_cnt + 2'h1;
    if (osc_cnt == 2'h3) begin
      osc <= ~osc;
    end
  end

  // n falling edges, each level held 2 or 3 clocks at random
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_in) count0 <= 1'b0;
      repeat (2 + ($urandom % 2)) @(posedge clock_in);
      count0 <= 1'b1;
      repeat (1 + ($urandom % 2)) @(posedge clock_in);
    end
  endtask

  // gate pin level, moved just after an edge
  task automatic set_gate(input logic v);
    @(posedge clock_in) timer0_gate_enable <= v;
  endtask

  // one comparator 1 pulse, high for three clocks, then idle low
  task automatic cmp_pulse();
    @(posedge clock_in) cmp1 <= 1'b1;
    repeat (3) @(posedge clock_in);
    cmp1 <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [quad_counter_timer_clocking_tb_top.sv]
// quad_counter_timer_clocking_tb_top.sv - self-checking bench of the timers
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  failures++; $display("wrong value %s expected %h seen %h", n, e, g); \
  end end
module quad_counter_timer_clocking_tb_top;
  logic                    clock_in;    // system clock
  logic                    reset_n_in;  // reset, active low
  qctc_pkg::qctc_bus_type  bus;         // register requests
  logic [7:0]              rd_data;     // read data
  qctc_pkg::qctc_pins_type pins;        // modelled pins
  logic                    tf0;         // timer 0 flag
  logic [5:0]              flags;       // all flags
  int                      failures;    // mismatches seen
  int                      check_count; // comparisons made
  logic [7:0]              v;           // last read value
  int                      n;           // random event count
  int                      divs[8] = '{12, 4, 48, 64, 1, 12, 1, 1};

  // ------------------------------------------------------------
  // design and far side
  // ------------------------------------------------------------
  qctc_top qctc_top_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .bus_in(bus), .rd_data_out(rd_data), .pins_in(pins),
    .timer0_overflow_flag_out(tf0), .overflow_flags_out(flags));
  qctc_pin_model qctc_pin_model_i (.clock_in(clock_in), .pins_out(pins));

  // 4 ns system clock
  always #2 clock_in = ~clock_in;

  // one write cycle, then one idle cycle
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_in) bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock_in) bus <= '0;
  endtask

  // read data is only valid in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge clock_in) bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clock_in) bus <= '0;
    #1 v = rd_data;
  endtask

  // ticks expected in the 242-cycle run window of one divider
  function automatic int ticks(input int d);
    return 242 / d;
  endfunction

  // verdict, reached from the main flow and the watchdog
  task automatic report_and_stop;
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog so that no hang runs open-ended
  initial begin
    repeat (100000) @(posedge clock_in);
    failures++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    reset_n_in = 1'b0;
    bus = '0;
    failures = 0;
    check_count = 0;
    void'($urandom(24));
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    // reset values, including an unmapped index
    foreach (divs[i]) begin
      rd(5'(i));
      `CHK("reset reg", 8'h00, v)
    end
    rd(5'h1F);
    `CHK("unmapped", 8'h00, v)
    // counter mode, random bursts at up to a quarter clock rate
    wr(qctc_pkg::A_T01_MODE, 8'h01);
    for (int k = 0; k < 3; k++) begin
      n = 1 + ($urandom % 60);
      wr(qctc_pkg::A_T0_LOW, 8'h00);
      wr(qctc_pkg::A_T01_CTL, 8'h05);
      qctc_pin_model_i.pulse(n);
      repeat (8) @(posedge clock_in);
      rd(qctc_pkg::A_T0_LOW);
      `CHK("event count", 8'(n), v)
    end
    // run bit off, then gate closed, then gate open
    wr(qctc_pkg::A_T0_LOW, 8'h00);
    wr(qctc_pkg::A_T01_CTL, 8'h04);
    qctc_pin_model_i.pulse(3);
    wr(qctc_pkg::A_T01_MODE, 8'h11);
    wr(qctc_pkg::A_T01_CTL, 8'h07);
    qctc_pin_model_i.pulse(4);
    qctc_pin_model_i.set_gate(1'b1);
    repeat (4) @(posedge clock_in);
    qctc_pin_model_i.pulse(2);
    repeat (8) @(posedge clock_in);
    rd(qctc_pkg::A_T0_LOW);
    `CHK("gated count", 8'h02, v)
    // 13-bit wrap from all ones sets the flag
    wr(qctc_pkg::A_T01_CTL, 8'h00);
    wr(qctc_pkg::A_T01_MODE, 8'h00);
    wr(qctc_pkg::A_T0_LOW, 8'h1F);
    wr(qctc_pkg::A_T0_HIGH, 8'hFF);
    wr(qctc_pkg::A_T01_CTL, 8'h05);
    qctc_pin_model_i.pulse(1);
    repeat (8) @(posedge clock_in);
    `CHK("wrap flag", 1'b1, tf0)
    `CHK("wrap flag vec", 1'b1, flags[0])
    rd(qctc_pkg::A_T0_HIGH);
    `CHK("wrap high", 8'h00, v)
    rd(qctc_pkg::A_T0_LOW);
    `CHK("wrap low", 8'h00, v)
    // 8-bit reload: low byte reloads, high byte unchanged
    wr(qctc_pkg::A_T01_CTL, 8'h00);
    // let the write settle before the flag is looked at
    #1;
    `CHK("flag cleared", 1'b0, tf0)
    wr(qctc_pkg::A_T01_MODE, 8'h02);
    wr(qctc_pkg::A_T0_HIGH, 8'hA5);
    wr(qctc_pkg::A_T0_LOW, 8'hFF);
    wr(qctc_pkg::A_T01_CTL, 8'h05);
    qctc_pin_model_i.pulse(1);
    repeat (8) @(posedge clock_in);
    `CHK("reload flag", 1'b1, tf0)
    rd(qctc_pkg::A_T0_LOW);
    `CHK("reload low", 8'hA5, v)
    rd(qctc_pkg::A_T0_HIGH);
    `CHK("reload high", 8'hA5, v)
    // clock sources: ticks in a fixed run, two ticks of slack either way
    wr(qctc_pkg::A_T01_CTL, 8'h00);
    wr(qctc_pkg::A_T01_MODE, 8'h01);
    foreach (divs[i]) begin
      logic [4:0] ca;
      logic [7:0] run;
      ca  = (i < 5) ? 5'h00 :
            (i < 7) ? qctc_pkg::A_T2_BASE : qctc_pkg::A_T3_BASE;
      run = (i < 6) ? 8'h01 : 8'h21;
      wr(qctc_pkg::A_CLK_CTL, (i < 4) ? 8'(i) : 8'h04);
      wr(ca + ((i < 5) ? 5'h03 : 5'h01), 8'h00);
      wr(ca, run);
      repeat (240) @(posedge clock_in);
      wr(ca, 8'h00);
      rd(ca + ((i < 5) ? 5'h03 : 5'h01));
      n = int'(v) - ticks(divs[i]);
      `CHK("tick count", 1'b1, (n <= 2 && n >= -2))
    end
    // timer 0 split: both bytes on the system clock, two flags
    wr(qctc_pkg::A_T0_LOW, 8'hF0);
    wr(qctc_pkg::A_T0_HIGH, 8'hF8);
    wr(qctc_pkg::A_T01_MODE, 8'h03);
    wr(qctc_pkg::A_T01_CTL, 8'h09);
    repeat (24) @(posedge clock_in);
    `CHK("split flags", 2'h3, flags[1:0])
    wr(qctc_pkg::A_T01_CTL, 8'h00);
    // timer 2 16-bit reload on the system clock
    wr(qctc_pkg::A_T2_BASE + qctc_pkg::OFF_RLD_L, 8'h40);
    wr(qctc_pkg::A_T2_BASE + qctc_pkg::OFF_CNT_L, 8'hF0);
    wr(qctc_pkg::A_T2_BASE + qctc_pkg::OFF_CNT_H, 8'hFF);
    wr(qctc_pkg::A_T2_BASE, 8'h21);
    repeat (20) @(posedge clock_in);
    `CHK("reload flag t2", 1'b1, flags[2])
    rd(qctc_pkg::A_T2_BASE + qctc_pkg::OFF_CNT_H);
    `CHK("reload high t2", 8'h00, v)
    rd(qctc_pkg::A_T2_BASE + qctc_pkg::OFF_CNT_L);
    `CHK("reload low t2", 1'b1, (v >= 8'h40 && v < 8'h60))
    // timer 3 captures its count at a comparator 1 rising edge
    wr(qctc_pkg::A_T3_BASE + qctc_pkg::OFF_CNT_L, 8'h00);
    wr(qctc_pkg::A_T3_BASE, 8'h35);
    qctc_pin_model_i.cmp_pulse();
    repeat (8) @(posedge clock_in);
    `CHK("capture flag", 1'b1, flags[4])
    rd(qctc_pkg::A_T3_BASE + qctc_pkg::OFF_RLD_L);
    `CHK("capture value", 8'h03, v)
    report_and_stop();
  end
endmodule
`default_nettype wire
